// ===== hdl/mpc_pin_ctrl.sv
// Pin control, monitor outputs and fault report of a motor driver core.
// Assumes one 25 MHz clock, a register port from the serial slave, and
// motor speed, commutation and variable data from the control core.
`timescale 1ns/1ps
`include "mpc_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Brake input high enters brake state and holds it until the input drops.
// - A configuration bit chooses low-side brake or align brake.
// - Motor is slowed to the brake threshold speed before braking.
// - A software override can replace the sensed brake pin level.
// - Direction high sequences A, B, C; low sequences A, C, B.
// - A software override can replace the sensed direction pin level.
// - Output disable high puts every bridge transistor in coast.
// - Output disable release restarts the motor.
// - Output disable never causes sleep or standby; core stays active.
// - Speed pin takes pulse-width, frequency or analog command and wakes.
// - Only the speed pin moves the device in and out of sleep.
// - Each monitor output shows its pointed variable, refreshed every 100 us.
// - Speed pulse output rate is proportional to motor speed.
// - Fault pin is active low; status registers hold fault details.
// - Alarm enabled: report-only faults raise alarm only.
// - Alarm enabled: actionable faults raise alarm and pull fault pin low.
// - Alarm disabled: alarm released, all faults pull fault pin low.
// - Pull-up select acts only after nonvolatile store and power cycle.
// - Pulse-width mode filters short glitches on the speed input.
// - Serial port configures nonvolatile settings and reads fault state.
// - A field selects the serial pins' pull-down strength.
module mpc_pin_ctrl
  import mpc_pkg::*;
#(
  parameter int SLEEP_CYCLES = `MPC_SLEEP_CYCLES_DEF,
  parameter int NFLT = 8
)
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [`MPC_AW-1:0] reg_addr_i,
  input wire logic [`MPC_DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`MPC_DW-1:0] reg_rdata_o,
  input wire logic brake_pin_i,
  input wire logic dir_pin_i,
  input wire logic output_disable_pin_i,
  input wire logic speed_pin_i,
  input wire logic [11:0] analog_speed_i,
  input wire logic [15:0] motor_speed_i,
  input wire logic commutate_i,
  input wire logic [15:0] var_data_i,
  input wire logic [NFLT-1:0] fault_act_i,
  input wire logic [NFLT-1:0] fault_rep_i,
  input wire logic nv_pullup_i,
  output logic [15:0] var_addr_o,
  output logic [15:0] monitor_out_one_o,
  output logic [15:0] monitor_out_two_o,
  output logic speed_pulse_out_o,
  output logic fault_out_n_o,
  output logic fault_out_n_oe_n_o,
  output logic alarm_o,
  output logic alarm_oe_n_o,
  output logic pullup_en_o,
  output logic [1:0] i2c_pd_strength_o,
  output logic nv_store_o,
  output logic nv_pullup_o,
  output logic [2:0] phase_o,
  output logic [1:0] bridge_mode_o,
  output logic [15:0] speed_limit_o,
  output logic [15:0] speed_cmd_o,
  output logic restart_o,
  output logic sleep_o
);

  function automatic logic hit(input logic [`MPC_AW-1:0] a, input logic [`MPC_AW-1:0] r);
    hit = (a == r);
  endfunction : hit

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0] brk_ff, dir_ff, dis_ff, spd_ff;
  logic brake_s, dir_s, outdis_s, speed_s;
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      brk_ff <= 2'h0;
      dir_ff <= 2'h0;
      dis_ff <= 2'h0;
      spd_ff <= 2'h0;
    end
    else
    begin
      brk_ff <= {brk_ff[0], brake_pin_i};
      dir_ff <= {dir_ff[0], dir_pin_i};
      dis_ff <= {dis_ff[0], output_disable_pin_i};
      spd_ff <= {spd_ff[0], speed_pin_i};
    end
  assign brake_s = brk_ff[1];
  assign dir_s = dir_ff[1];
  assign outdis_s = dis_ff[1];
  assign speed_s = spd_ff[1];

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [`MPC_DW-1:0] ctrl, brk_thr, glitch_len, mon1_ptr, mon2_ptr, speed_meas;
  logic [NFLT-1:0] flt_act, flt_rep;
  mpc_state_type state;
  logic pullup_active;
  logic brake_eff, dir_eff;
  mpc_speed_mode_type speed_mode;

  assign brake_eff = ctrl[`MPC_BIT_BRK_OVR_EN] ? ctrl[`MPC_BIT_BRK_OVR_VAL] : brake_s;
  assign dir_eff = ctrl[`MPC_BIT_DIR_OVR_EN] ? ctrl[`MPC_BIT_DIR_OVR_VAL] : dir_s;
  assign speed_mode = mpc_speed_mode_type'(ctrl[`MPC_MODE_MSB:`MPC_MODE_LSB]);

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      ctrl <= `MPC_CTRL_RST;
      brk_thr <= `MPC_BRK_THR_RST;
      glitch_len <= `MPC_GLITCH_RST;
      mon1_ptr <= 16'h0000;
      mon2_ptr <= 16'h0000;
    end
    else if (reg_wr_i)
    begin
      if (hit(reg_addr_i, `MPC_ADDR_CTRL))
        ctrl <= reg_wdata_i;
      if (hit(reg_addr_i, `MPC_ADDR_BRK_THR))
        brk_thr <= reg_wdata_i;
      if (hit(reg_addr_i, `MPC_ADDR_GLITCH))
        glitch_len <= reg_wdata_i;
      if (hit(reg_addr_i, `MPC_ADDR_MON1_PTR))
        mon1_ptr <= reg_wdata_i;
      if (hit(reg_addr_i, `MPC_ADDR_MON2_PTR))
        mon2_ptr <= reg_wdata_i;
    end

  // Sticky fault status, write one to clear; a new fault wins over the clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      flt_act <= '0;
      flt_rep <= '0;
    end
    else
    begin
      flt_act <= (flt_act & ~((reg_wr_i && hit(reg_addr_i, `MPC_ADDR_FLT_ACT)) ?
                 reg_wdata_i[NFLT-1:0] : '0)) | fault_act_i;
      flt_rep <= (flt_rep & ~((reg_wr_i && hit(reg_addr_i, `MPC_ADDR_FLT_REP)) ?
                 reg_wdata_i[NFLT-1:0] : '0)) | fault_rep_i;
    end

  // Read data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
      reg_rdata_o <= '0;
    else if (!reg_rd_i)
      reg_rdata_o <= '0;
    else
      case (reg_addr_i)
        `MPC_ADDR_CTRL: reg_rdata_o <= ctrl;
        `MPC_ADDR_BRK_THR: reg_rdata_o <= brk_thr;
        `MPC_ADDR_GLITCH: reg_rdata_o <= glitch_len;
        `MPC_ADDR_MON1_PTR: reg_rdata_o <= mon1_ptr;
        `MPC_ADDR_MON2_PTR: reg_rdata_o <= mon2_ptr;
        `MPC_ADDR_FLT_ACT: reg_rdata_o <= `MPC_DW'(flt_act);
        `MPC_ADDR_FLT_REP: reg_rdata_o <= `MPC_DW'(flt_rep);
        `MPC_ADDR_STATUS: reg_rdata_o <= {7'h00, pullup_active, speed_s, outdis_s, dir_eff, brake_eff, 1'b0, state};
        `MPC_ADDR_SPEED: reg_rdata_o <= speed_meas;
        default: reg_rdata_o <= '0;
      endcase

  //////////////////////////////////////////////////////////////////////////////
  // Nonvolatile pull-up: stored on command, taken only at power-up
  logic pu_taken;
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      pu_taken <= 1'b0;
      pullup_active <= 1'b0;
    end
    else if (!pu_taken)
    begin
      pu_taken <= 1'b1;
      pullup_active <= nv_pullup_i;
    end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      nv_store_o <= 1'b0;
      nv_pullup_o <= 1'b0;
    end
    else
    begin
      nv_store_o <= reg_wr_i && hit(reg_addr_i, `MPC_ADDR_NV) && reg_wdata_i[`MPC_BIT_NV_STORE];
      if (reg_wr_i && hit(reg_addr_i, `MPC_ADDR_NV) && reg_wdata_i[`MPC_BIT_NV_STORE])
        nv_pullup_o <= ctrl[`MPC_BIT_PULLUP];
    end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      pullup_en_o <= 1'b0;
      i2c_pd_strength_o <= 2'h0;
    end
    else
    begin
      pullup_en_o <= pullup_active;
      i2c_pd_strength_o <= ctrl[`MPC_PD_MSB:`MPC_PD_LSB];
    end

  //////////////////////////////////////////////////////////////////////////////
  // Speed input: glitch filter, measurement, sleep timer
  logic [15:0] glitch_cnt, hi_cnt, per_cnt;
  logic spd_filt, spd_prev, sleep_req;
  logic [31:0] low_cnt;
  logic spd_use;
  assign spd_use = (speed_mode == SM_PWM) ? spd_filt : speed_s;

  // Level must stay stable past the filter length to be accepted
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      spd_filt <= 1'b0;
      glitch_cnt <= 16'h0000;
    end
    else if (speed_s == spd_filt)
      glitch_cnt <= 16'h0000;
    else if (glitch_cnt >= glitch_len)
    begin
      spd_filt <= speed_s;
      glitch_cnt <= 16'h0000;
    end
    else
      glitch_cnt <= glitch_cnt + 16'h0001;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      spd_prev <= 1'b0;
      hi_cnt <= 16'h0000;
      per_cnt <= 16'h0000;
      speed_meas <= 16'h0000;
    end
    else
    begin
      spd_prev <= spd_use;
      if (speed_mode == SM_ANALOG)
        speed_meas <= {4'h0, analog_speed_i};
      else if (spd_use && !spd_prev)
      begin
        speed_meas <= (speed_mode == SM_PWM) ? hi_cnt : per_cnt;
        hi_cnt <= 16'h0000;
        per_cnt <= 16'h0001;
      end
      else
      begin
        per_cnt <= (per_cnt == 16'hFFFF) ? per_cnt : per_cnt + 16'h0001;
        if (spd_use && hi_cnt != 16'hFFFF)
          hi_cnt <= hi_cnt + 16'h0001;
      end
    end

  // Sleep only from a long low on the speed pin
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      low_cnt <= 32'h0000_0000;
      sleep_req <= 1'b0;
    end
    else if (spd_use)
    begin
      low_cnt <= 32'h0000_0000;
      sleep_req <= 1'b0;
    end
    else if (low_cnt >= 32'(SLEEP_CYCLES - 1))
      sleep_req <= 1'b1;
    else
      low_cnt <= low_cnt + 32'h0000_0001;

  //////////////////////////////////////////////////////////////////////////////
  // Motor state: sleep over output disable over brake
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
      state <= ST_RUN;
    else
      case (state)
        ST_RUN:
          if (sleep_req)
            state <= ST_SLEEP;
          else if (outdis_s)
            state <= ST_COAST;
          else if (brake_eff)
            state <= ST_SLOW;
        ST_SLOW:
          if (sleep_req)
            state <= ST_SLEEP;
          else if (outdis_s)
            state <= ST_COAST;
          else if (!brake_eff)
            state <= ST_RUN;
          else if (motor_speed_i <= brk_thr)
            state <= ST_BRAKE;
        ST_BRAKE:
          if (sleep_req)
            state <= ST_SLEEP;
          else if (outdis_s)
            state <= ST_COAST;
          else if (!brake_eff)
            state <= ST_RESTART;
        ST_COAST:
          if (sleep_req)
            state <= ST_SLEEP;
          else if (!outdis_s)
            state <= ST_RESTART;
        ST_RESTART:
          state <= ST_RUN;
        ST_SLEEP:
          if (!sleep_req)
            state <= outdis_s ? ST_COAST : ST_RESTART;
        default:
          state <= ST_RUN;
      endcase

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      bridge_mode_o <= BR_COAST;
      speed_limit_o <= 16'hFFFF;
      restart_o <= 1'b0;
      sleep_o <= 1'b0;
      speed_cmd_o <= 16'h0000;
    end
    else
    begin
      case (state)
        ST_RUN, ST_SLOW, ST_RESTART: bridge_mode_o <= BR_DRIVE;
        ST_BRAKE: bridge_mode_o <= ctrl[`MPC_BIT_BRK_STYLE] ? BR_ALIGN : BR_LOW_BRAKE;
        default: bridge_mode_o <= BR_COAST;
      endcase
      speed_limit_o <= (state == ST_SLOW || state == ST_BRAKE) ? brk_thr : 16'hFFFF;
      restart_o <= (state == ST_RESTART);
      sleep_o <= (state == ST_SLEEP);
      speed_cmd_o <= speed_meas;
    end

  // Commutation order follows direction
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
      phase_o <= 3'h1;
    else if (commutate_i && (state == ST_RUN || state == ST_SLOW))
      phase_o <= dir_eff ? {phase_o[1:0], phase_o[2]} : {phase_o[0], phase_o[2:1]};

  //////////////////////////////////////////////////////////////////////////////
  // Monitor outputs: both pointers per refresh cycle, one fetch each
  logic [11:0] mon_cnt;
  logic mon_tick, fetch1, fetch2;
  assign mon_tick = (mon_cnt == 12'(`MPC_MON_CYCLES - 1));
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      mon_cnt <= 12'h000;
      fetch1 <= 1'b0;
      fetch2 <= 1'b0;
      var_addr_o <= 16'h0000;
      monitor_out_one_o <= 16'h0000;
      monitor_out_two_o <= 16'h0000;
    end
    else
    begin
      mon_cnt <= mon_tick ? 12'h000 : mon_cnt + 12'h001;
      fetch1 <= mon_tick;
      fetch2 <= fetch1;
      if (mon_tick)
        var_addr_o <= mon1_ptr;
      else if (fetch1)
        var_addr_o <= mon2_ptr;
      if (fetch1)
        monitor_out_one_o <= var_data_i;
      if (fetch2)
        monitor_out_two_o <= var_data_i;
    end

  //////////////////////////////////////////////////////////////////////////////
  // Speed pulse: phase accumulator, carry rate tracks motor speed
  logic [16:0] acc;
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      acc <= 17'h00000;
      speed_pulse_out_o <= 1'b0;
    end
    else
    begin
      acc <= {1'b0, acc[15:0]} + {1'b0, motor_speed_i};
      if (acc[16])
        speed_pulse_out_o <= ~speed_pulse_out_o;
    end

  //////////////////////////////////////////////////////////////////////////////
  // Fault pins: the fault pin is open drain, the alarm pin three-state
  logic act_any, rep_any, alarm_en;
  assign act_any = |flt_act;
  assign rep_any = |flt_rep;
  assign alarm_en = ctrl[`MPC_BIT_ALARM_EN];
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
    begin
      fault_out_n_o <= 1'b0;
      fault_out_n_oe_n_o <= 1'b1;
      alarm_o <= 1'b0;
      alarm_oe_n_o <= 1'b1;
    end
    else
    begin
      fault_out_n_o <= 1'b0;
      fault_out_n_oe_n_o <= alarm_en ? !act_any : !(act_any || rep_any);
      alarm_o <= alarm_en && (act_any || rep_any);
      alarm_oe_n_o <= !alarm_en;
    end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_mon_fetch;
    mon_tick ##1 (var_addr_o == $past(mon1_ptr));
  endsequence
  sequence s_restart;
    (state == ST_RESTART) ##1 (state == ST_RUN && restart_o);
  endsequence

  property p_sync;
    @(posedge clk_sys_i) disable iff (!rst_n_i) ##2 (brake_s == $past(brake_pin_i, 2));
  endproperty
  a_sync: assert property (p_sync) else $error("brake sync depth wrong");

  property p_brake_hold;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == ST_BRAKE && brake_eff && !outdis_s && !sleep_req) |=> (state == ST_BRAKE);
  endproperty
  a_brake_hold: assert property (p_brake_hold) else $error("left brake while held");

  property p_brake_style;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == ST_BRAKE) |=> (bridge_mode_o == ($past(ctrl[`MPC_BIT_BRK_STYLE]) ? BR_ALIGN : BR_LOW_BRAKE));
  endproperty
  a_brake_style: assert property (p_brake_style) else $error("brake style wrong");

  property p_slow_first;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == ST_RUN && brake_eff && !outdis_s && !sleep_req) |=> (state == ST_SLOW) ##1 (speed_limit_o == brk_thr);
  endproperty
  a_slow_first: assert property (p_slow_first) else $error("brake entered without slowing");

  property p_brake_ovr;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      ctrl[`MPC_BIT_BRK_OVR_EN] |-> (brake_eff == ctrl[`MPC_BIT_BRK_OVR_VAL]);
  endproperty
  a_brake_ovr: assert property (p_brake_ovr) else $error("brake override ignored");

  property p_dir_seq;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (commutate_i && state == ST_RUN && phase_o == 3'h1) |=> (phase_o == ($past(dir_eff) ? 3'h2 : 3'h4));
  endproperty
  a_dir_seq: assert property (p_dir_seq) else $error("phase order wrong");

  property p_coast;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (outdis_s && state != ST_COAST && !sleep_req) |=> (state == ST_COAST) ##1 (bridge_mode_o == BR_COAST);
  endproperty
  a_coast: assert property (p_coast) else $error("no coast on output disable");

  property p_restart;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == ST_COAST && !outdis_s && !sleep_req) |=> s_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart after enable");

  property p_no_sleep;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!sleep_req && state != ST_SLEEP) |=> (state != ST_SLEEP);
  endproperty
  a_no_sleep: assert property (p_no_sleep) else $error("sleep without speed pin");

  property p_monitor;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      s_mon_fetch |=> (monitor_out_one_o == $past(var_data_i));
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor one not refreshed");

  property p_alarm_rep;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (alarm_en && !act_any && rep_any) |=> (alarm_o && fault_out_n_oe_n_o && !alarm_oe_n_o);
  endproperty
  a_alarm_rep: assert property (p_alarm_rep) else $error("report fault on fault pin");

  property p_alarm_act;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (alarm_en && act_any) |=> (alarm_o && !fault_out_n_oe_n_o);
  endproperty
  a_alarm_act: assert property (p_alarm_act) else $error("actionable fault not on both pins");

  property p_alarm_off;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!alarm_en && (act_any || rep_any)) |=> (alarm_oe_n_o && !fault_out_n_oe_n_o);
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("fault pin idle with alarm off");

  property p_set_wins;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      fault_act_i[0] |=> flt_act[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("fault lost on clear");

  property p_pullup;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      (pu_taken && $changed(ctrl[`MPC_BIT_PULLUP])) |=> $stable(pullup_active);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up changed before power cycle");

endmodule : mpc_pin_ctrl

// ===== hdl/mpc_params.svh
// Constants for the motor pin control and fault report block.
// Included by the package and the design; holds definitions only.
`ifndef MPC_PARAMS_SVH
`define MPC_PARAMS_SVH
`define MPC_AW 8
`define MPC_DW 16
`define MPC_ADDR_CTRL 8'h00
`define MPC_ADDR_BRK_THR 8'h04
`define MPC_ADDR_GLITCH 8'h08
`define MPC_ADDR_MON1_PTR 8'h0C
`define MPC_ADDR_MON2_PTR 8'h10
`define MPC_ADDR_FLT_ACT 8'h14
`define MPC_ADDR_FLT_REP 8'h18
`define MPC_ADDR_STATUS 8'h1C
`define MPC_ADDR_SPEED 8'h20
`define MPC_ADDR_NV 8'h24
`define MPC_CTRL_RST 16'h0000
`define MPC_BRK_THR_RST 16'h0000
`define MPC_GLITCH_RST 16'h0004
`define MPC_BIT_BRK_OVR_EN 0
`define MPC_BIT_BRK_OVR_VAL 1
`define MPC_BIT_DIR_OVR_EN 2
`define MPC_BIT_DIR_OVR_VAL 3
`define MPC_BIT_BRK_STYLE 4
`define MPC_BIT_ALARM_EN 5
`define MPC_BIT_PULLUP 6
`define MPC_MODE_LSB 7
`define MPC_MODE_MSB 8
`define MPC_PD_LSB 9
`define MPC_PD_MSB 10
`define MPC_BIT_NV_STORE 0
`define MPC_CLK_PERIOD_NS 40
`define MPC_MON_PERIOD_NS 100000
`define MPC_MON_CYCLES (`MPC_MON_PERIOD_NS / `MPC_CLK_PERIOD_NS)
`define MPC_SLEEP_CYCLES_DEF 25000
`endif

// ===== hdl/mpc_pkg.sv
// Types for the motor pin control and fault report block.
// Assumes mpc_params.svh is on the include path.
`include "mpc_params.svh"
package mpc_pkg;
  typedef enum logic [2:0]
  {
    ST_RUN = 3'h0,
    ST_SLOW = 3'h1,
    ST_BRAKE = 3'h3,
    ST_COAST = 3'h2,
    ST_RESTART = 3'h6,
    ST_SLEEP = 3'h7
  } mpc_state_type;
  typedef enum logic [1:0]
  {
    BR_DRIVE = 2'h0,
    BR_COAST = 2'h1,
    BR_LOW_BRAKE = 2'h2,
    BR_ALIGN = 2'h3
  } mpc_bridge_type;
  typedef enum logic [1:0]
  {
    SM_PWM = 2'h0,
    SM_FREQ = 2'h1,
    SM_ANALOG = 2'h2
  } mpc_speed_mode_type;
endpackage : mpc_pkg

// ===== test/mpc_core_model.sv
// Behavioural motor core facing the pin block: speed and variable data.
// Assumes the block's clock and reset; one register of speed lag.
`timescale 1ns/1ps
module mpc_core_model
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [15:0] target_i,
  input wire logic [15:0] speed_limit_i,
  input wire logic [15:0] var_addr_i,
  output logic [15:0] motor_speed_o,
  output logic [15:0] var_data_o
);
  // Speed obeys the limit one clock later with no ramp, so the model delays braking by one cycle at most
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      motor_speed_o <= 16'h0000;
    else
      motor_speed_o <= (target_i < speed_limit_i) ? target_i : speed_limit_i;
  end
  assign var_data_o = var_addr_i ^ 16'hA5A5;
endmodule : mpc_core_model

// ===== test/motor_pin_control_fault_report_tb_top.sv
// Self-checking bench of the pin control block beside a behavioural core.
// Assumes the block's package; sleep count cut to 20 cycles.
`timescale 1ns/1ps
module motor_pin_control_fault_report_tb_top;
  import mpc_pkg::*;
  logic [15:0] reg_rdata_o, var_addr_o, monitor_out_one_o, monitor_out_two_o, speed_limit_o, speed_cmd_o;
  logic [15:0] motor_speed_i, var_data_i, reg_wdata_i = 16'h0000, tgt = 16'h4000, v, thr;
  logic [11:0] analog_speed_i = 12'h000;
  logic [7:0] reg_addr_i = 8'h00, fault_act_i = 8'h00, fault_rep_i = 8'h00;
  logic [2:0] phase_o, p;
  logic [1:0] bridge_mode_o, i2c_pd_strength_o;
  logic clk_sys_i = 1'h0, rst_n_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0, brake_pin_i = 1'h0, dir_pin_i = 1'h0;
  logic output_disable_pin_i = 1'h0, speed_pin_i = 1'h1, commutate_i = 1'h0, nv_pullup_i = 1'h0, a, f;
  logic speed_pulse_out_o, fault_out_n_o, fault_out_n_oe_n_o, alarm_o, alarm_oe_n_o, pullup_en_o;
  logic nv_store_o, nv_pullup_o, restart_o, sleep_o;
  int errors = 0, n_compared = 0, i, j, k, c;
  mpc_pin_ctrl #(.SLEEP_CYCLES(20), .NFLT(8)) i_mpc_pin_ctrl (.*);
  mpc_core_model i_mpc_core_model (.clk_sys_i, .rst_n_i, .target_i(tgt), .speed_limit_i(speed_limit_o),
    .var_addr_i(var_addr_o), .motor_speed_o(motor_speed_i), .var_data_o(var_data_i));
  always #20 clk_sys_i = ~clk_sys_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // A wait that ran out ends the run at once
  task automatic hit(input logic ok);
    chk(16'(ok), 16'h0001);
    if (ok !== 1'h1)
      tally_and_finish();
  endtask : hit
  task automatic edge_up();
    @(posedge clk_sys_i);
  endtask : edge_up
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc
  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    edge_up();
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    edge_up();
    reg_wr_i <= 1'h0;
  endtask : wr
  task automatic rdc(input logic [7:0] ad, input logic [15:0] e);
    edge_up();
    reg_addr_i <= ad;
    reg_rd_i <= 1'h1;
    edge_up();
    reg_rd_i <= 1'h0;
    cyc(1);
    chk(reg_rdata_o, e);
  endtask : rdc
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) edge_up();
    errors++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(6512));
    repeat (8) edge_up();
    rst_n_i <= 1'h1;
    cyc(3);
    chk(16'({fault_out_n_oe_n_o, alarm_oe_n_o, pullup_en_o}), 16'h0006);
    rdc(8'h08, 16'h0004);
    rdc(8'h3C, 16'h0000);
    for (j = 0; j < 2; j++)
    begin
      thr = 16'h0100 + 16'($urandom_range(255));
      wr(8'h04, thr);
      wr(8'h00, j ? 16'h0013 : 16'h0000);
      edge_up();
      brake_pin_i <= (j == 0);
      for (k = 0; k < 9 && speed_limit_o !== thr; k++)
        cyc(1);
      hit(speed_limit_o === thr);
      for (k = 0; k < 20 && bridge_mode_o !== 2'(2 + j); k++)
        cyc(1);
      cyc(10);
      chk(16'(bridge_mode_o), 16'(2 + j));
      edge_up();
      brake_pin_i <= 1'h0;
      wr(8'h00, 16'h0000);
      for (k = 0; k < 20 && restart_o !== 1'h1; k++)
        cyc(1);
      hit(restart_o);
    end
    for (i = 0; i < 12; i++)
    begin
      a = 1'($urandom);
      f = 1'($urandom);
      edge_up();
      dir_pin_i <= a ^ f;
      wr(8'h00, {12'h000, f, a, 2'h0});
      cyc(4);
      p = phase_o;
      edge_up();
      commutate_i <= 1'h1;
      edge_up();
      commutate_i <= 1'h0;
      cyc(3);
      chk(16'(phase_o), 16'(f ? {p[1:0], p[2]} : {p[0], p[2:1]}));
    end
    edge_up();
    output_disable_pin_i <= 1'h1;
    for (k = 0; k < 10 && bridge_mode_o !== BR_COAST; k++)
      cyc(1);
    hit(bridge_mode_o === BR_COAST);
    wr(8'h04, 16'h1234);
    rdc(8'h04, 16'h1234);
    chk(16'(sleep_o), 16'h0000);
    edge_up();
    output_disable_pin_i <= 1'h0;
    for (k = 0; k < 10 && restart_o !== 1'h1; k++)
      cyc(1);
    hit(restart_o);
    edge_up();
    speed_pin_i <= 1'h0;
    for (k = 0; k < 40 && sleep_o !== 1'h1; k++)
      cyc(1);
    hit(sleep_o);
    edge_up();
    speed_pin_i <= 1'h1;
    for (k = 0; k < 20 && sleep_o !== 1'h0; k++)
      cyc(1);
    hit(sleep_o === 1'h0);
    for (i = 0; i < 8; i++)
    begin
      a = 1'($urandom);
      f = 1'($urandom);
      c = $urandom_range(7);
      wr(8'h00, {10'h000, a, 5'h00});
      edge_up();
      if (f)
        fault_act_i <= 8'(1 << c);
      else
        fault_rep_i <= 8'(1 << c);
      edge_up();
      fault_act_i <= 8'h00;
      fault_rep_i <= 8'h00;
      cyc(3);
      chk(16'({fault_out_n_oe_n_o, alarm_oe_n_o}), 16'({a && !f, !a}));
      chk(16'(a ? alarm_o : fault_out_n_o), 16'(a));
      rdc(f ? 8'h14 : 8'h18, 16'(1 << c));
      wr(8'h14, 16'hFFFF);
      wr(8'h18, 16'hFFFF);
      cyc(2);
      chk(16'(fault_out_n_oe_n_o), 16'h0001);
    end
    v = 16'($urandom_range(3));
    wr(8'h00, {5'h00, v[1:0], 9'h040});
    cyc(2);
    chk(16'(i2c_pd_strength_o), v);
    wr(8'h24, 16'h0001);
    cyc(1);
    for (k = 0; k < 4 && nv_store_o !== 1'h1; k++)
      cyc(1);
    hit(nv_store_o);
    chk(16'({nv_pullup_o, pullup_en_o}), 16'h0002);
    edge_up();
    analog_speed_i <= 12'($urandom);
    wr(8'h00, 16'h0100);
    cyc(6);
    chk(speed_cmd_o, {4'h0, analog_speed_i});
    rdc(8'h20, {4'h0, analog_speed_i});
    wr(8'h00, 16'h0000);
    for (j = 0; j < 2; j++)
    begin
      edge_up();
      tgt <= j ? 16'hFFFF : 16'h4000;
      k = j ? 1024 : 256;
      cyc(4);
      c = 0;
      f = speed_pulse_out_o;
      repeat (1024)
      begin
        cyc(1);
        c += int'(speed_pulse_out_o !== f);
        f = speed_pulse_out_o;
      end
      chk(16'(c > k - 3 && c < k + 2), 16'h0001);
    end
    v = 16'($urandom);
    wr(8'h0C, v);
    wr(8'h10, ~v);
    for (k = 0; k < 5100 && monitor_out_two_o !== (~v ^ 16'hA5A5); k++)
      cyc(1);
    hit(monitor_out_two_o === (~v ^ 16'hA5A5));
    chk(monitor_out_one_o, v ^ 16'hA5A5);
    // Power cycle: the stored pull-up bit takes effect only now
    edge_up();
    nv_pullup_i <= 1'h1;
    rst_n_i <= 1'h0;
    repeat (2) edge_up();
    rst_n_i <= 1'h1;
    cyc(3);
    chk(16'({pullup_en_o, bridge_mode_o}), 16'h0004);
    tally_and_finish();
  end
endmodule : motor_pin_control_fault_report_tb_top
